/* hw/cki_pkg.sv */
// Package for the carkit ID interrupt block: offsets, fields, carriers.
// Assumes a 32-bit APB master with byte addresses, one word per register.
package cki_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_EN_WR = 8'h1d;
    localparam logic [7:0] IDX_EN_SET = 8'h1e;
    localparam logic [7:0] IDX_EN_CLR = 8'h1f;
    localparam logic [7:0] IDX_STATE = 8'h20;
    localparam logic [7:0] IDX_LATCHED = 8'h21;
    localparam logic [7:0] IDX_EVT_STS = 8'h22;
    localparam logic [7:0] IDX_EVT_CLR = 8'h23;
    localparam logic [7:0] IDX_EVT_EN = 8'h24;
    // Enable register fields
    localparam int EN_RISE_BIT = 0;
    localparam int EN_FALL_BIT = 1;
    localparam int EN_MEAS_BIT = 5;
    localparam logic [7:0] EN_WR_MASK = 8'h23;
    localparam logic [7:0] EN_RESET = 8'h00;
    // State register fields
    localparam int ST_OPEN_BIT = 0;
    localparam int ST_CODE_LSB = 3;
    localparam int ST_DONE_BIT = 6;
    // Latched register fields
    localparam int LT_OPEN_BIT = 0;
    localparam int LT_MEAS_BIT = 3;
    // Event status fields
    localparam int EV_OPEN_BIT = 0;
    localparam int EV_MEAS_BIT = 1;
    localparam int EV_W = 2;
    // Resistance codes
    typedef enum logic [2:0] {
        CKI_R_0 = 3'b000,
        CKI_R_75 = 3'b001,
        CKI_R_100K = 3'b010,
        CKI_R_440K = 3'b100,
        CKI_R_OPEN = 3'b101,
        CKI_R_ERR = 3'b111
    } cki_rcode_t;
    localparam logic [2:0] CODE_RESET = 3'b000;
    // Measurement duration
    localparam int MEAS_TIME_NS = 282000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int MEAS_CYCLES = MEAS_TIME_NS / CLK_PERIOD_NS;
    // APB carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } cki_apb_req_t;
    typedef struct packed {
        logic pready;
        logic [DATA_W-1:0] prdata;
        logic pslverr;
    } cki_apb_rsp_t;
endpackage : cki_pkg

/* hw/cki_irq.sv */
// Carkit ID interrupt enable, state and latched registers behind APB.
// Assumes the open comparator is asynchronous; converter strobes and the
// vendor register signals come from logic on clk.
//
// Behaviour
// - Rise enable: open edge raises alt_int
// - Fall enable: close edge raises alt_int
// - Unimplemented bits ignore writes, read zero
// - Measure enable ORed with vendor enable
// - Enable: write, set, clear; all read
// - State register read-only
// - State bit 0 shows live open
// - State bits 5:3 hold resistance code
// - Code and done mirror vendor register
// - Done sets when measurement finishes
// - Vendor code read clears done
// - State register read keeps done
// - Latched bit 0 on enabled open edges
// - Latched bit 3 on enabled done rise
// - Latched register read clears it
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module cki_irq
    import cki_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire cki_apb_req_t apb_req,
    output cki_apb_rsp_t apb_rsp,
    // ID comparator and converter
    input wire logic id_open_raw,
    input wire logic meas_done_stb,
    input wire logic [2:0] meas_code,
    // Vendor conversion register
    input wire logic vendor_meas_irq_en,
    input wire logic vendor_code_rd,
    output logic id_measure_done,
    output logic [2:0] id_resistance_code,
    // Interrupt outputs
    output logic alt_int,
    output logic irq
);
    logic open_s1_q;
    logic open_s2_q;
    logic open_prev_q;
    logic [7:0] en_q;
    logic done_q;
    logic [2:0] code_q;
    logic lat_open_q;
    logic lat_meas_q;
    logic [EV_W-1:0] ev_sts_q;
    logic [EV_W-1:0] ev_sts_d;
    logic [EV_W-1:0] ev_en_q;
    logic alt_int_q;
    logic irq_q;
    cki_apb_rsp_t rsp_q;
    logic [2:0] vld_q;
    logic sync_ok;
    logic lat_rd_setup;
    logic lat_rd_done;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic setup;
    logic done_xfer;
    logic wr_xfer;
    logic rd_xfer;
    logic [7:0] idx;
    logic addr_ok;
    logic idx_hit;
    logic open_rise;
    logic open_fall;
    logic open_evt;
    logic meas_en;
    logic meas_evt;
    logic [7:0] en_wdata;
    logic [7:0] state_rd;
    logic [7:0] latched_rd;
    logic [DATA_W-1:0] rd_mux;

    // Bus phase decode
    assign setup = apb_req.psel & ~apb_req.penable;
    assign done_xfer = apb_req.psel & apb_req.penable & rsp_q.pready;
    assign wr_xfer = done_xfer & apb_req.pwrite;
    assign rd_xfer = done_xfer & ~apb_req.pwrite;
    assign idx = {2'b00, apb_req.paddr[ADDR_W-1:2]};
    assign addr_ok = (apb_req.paddr[1:0] == 2'b00) & idx_hit;
    assign en_wdata = apb_req.pwdata[7:0] & EN_WR_MASK;

    always_comb begin
        case (idx)
            IDX_EN_WR, IDX_EN_SET, IDX_EN_CLR, IDX_STATE, IDX_LATCHED,
            IDX_EVT_STS, IDX_EVT_CLR, IDX_EVT_EN: idx_hit = 1'b1;
            default: idx_hit = 1'b0;
        endcase
    end

    // ID open synchroniser and edge detect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            open_s1_q <= 1'b0;
            open_s2_q <= 1'b0;
            open_prev_q <= 1'b0;
        end else begin
            open_s1_q <= id_open_raw;
            open_s2_q <= open_s1_q;
            open_prev_q <= open_s2_q;
        end
    end

    // Edge detect waits until the synchroniser holds pin values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vld_q <= 3'b000;
        end else begin
            vld_q <= {vld_q[1:0], 1'b1};
        end
    end

    assign sync_ok = vld_q[2];
    assign open_rise = sync_ok & open_s2_q & ~open_prev_q;
    assign open_fall = sync_ok & ~open_s2_q & open_prev_q;
    assign open_evt = (open_rise & en_q[EN_RISE_BIT])
        | (open_fall & en_q[EN_FALL_BIT]);
    assign meas_en = en_q[EN_MEAS_BIT] | vendor_meas_irq_en;
    assign meas_evt = meas_en & meas_done_stb & ~done_q;

    // Enable register: write, set and clear views
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= EN_RESET;
        end else if (wr_xfer) begin
            case (idx)
                IDX_EN_WR: en_q <= en_wdata;
                IDX_EN_SET: en_q <= en_q | en_wdata;
                IDX_EN_CLR: en_q <= en_q & ~en_wdata;
                default: en_q <= en_q;
            endcase
        end
    end

    // Measurement done flag and code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            code_q <= CODE_RESET;
        end else begin
            if (meas_done_stb) begin
                done_q <= 1'b1;
                code_q <= meas_code;
            end else if (vendor_code_rd) begin
                done_q <= 1'b0;
            end
        end
    end

    // Latched register: clear what was read, new events win
    assign lat_rd_setup = setup & ~apb_req.pwrite & (idx == IDX_LATCHED);
    assign lat_rd_done = rd_xfer & (idx == IDX_LATCHED);

    cki_rc_bit u_lat_open (
        .clk(clk),
        .rst(rst),
        .set(open_evt),
        .rd_setup(lat_rd_setup),
        .rd_done(lat_rd_done),
        .flag(lat_open_q)
    );

    cki_rc_bit u_lat_meas (
        .clk(clk),
        .rst(rst),
        .set(meas_evt),
        .rd_setup(lat_rd_setup),
        .rd_done(lat_rd_done),
        .flag(lat_meas_q)
    );

    // Sticky event status with write-one-to-clear
    assign ev_clr = {EV_W{wr_xfer && idx == IDX_EVT_CLR}}
        & apb_req.pwdata[EV_W-1:0];
    assign ev_set[EV_OPEN_BIT] = open_evt;
    assign ev_set[EV_MEAS_BIT] = meas_evt;

    for (genvar i = 0; i < EV_W; i++) begin : g_ev
        cki_sticky_bit u_sts (
            .clk(clk),
            .rst(rst),
            .set(ev_set[i]),
            .clr(ev_clr[i]),
            .flag_d(ev_sts_d[i]),
            .flag(ev_sts_q[i])
        );
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_en_q <= '0;
        end else if (wr_xfer && idx == IDX_EVT_EN) begin
            ev_en_q <= apb_req.pwdata[EV_W-1:0];
        end
    end

    // Interrupt outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alt_int_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            alt_int_q <= open_evt | meas_evt;
            irq_q <= |(ev_sts_d & ev_en_q);
        end
    end

    // Read data views
    always_comb begin
        state_rd = 8'h00;
        state_rd[ST_OPEN_BIT] = open_s2_q;
        state_rd[ST_CODE_LSB +: 3] = code_q;
        state_rd[ST_DONE_BIT] = done_q;
        latched_rd = 8'h00;
        latched_rd[LT_OPEN_BIT] = lat_open_q;
        latched_rd[LT_MEAS_BIT] = lat_meas_q;
    end

    always_comb begin
        case (idx)
            IDX_EN_WR, IDX_EN_SET, IDX_EN_CLR:
                rd_mux = {24'h000000, en_q};
            IDX_STATE: rd_mux = {24'h000000, state_rd};
            IDX_LATCHED: rd_mux = {24'h000000, latched_rd};
            IDX_EVT_STS: rd_mux = {30'h00000000, ev_sts_q};
            IDX_EVT_EN: rd_mux = {30'h00000000, ev_en_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // APB response: ready in the first access cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.pready <= setup;
            if (setup) begin
                rsp_q.pslverr <= ~addr_ok;
                rsp_q.prdata <= (addr_ok & ~apb_req.pwrite)
                    ? rd_mux : 32'h00000000;
            end else begin
                rsp_q.pslverr <= 1'b0;
                rsp_q.prdata <= 32'h00000000;
            end
        end
    end

    assign apb_rsp = rsp_q;
    assign id_measure_done = done_q;
    assign id_resistance_code = code_q;
    assign alt_int = alt_int_q;
    assign irq = irq_q;
endmodule : cki_irq

// Sticky flag: an event sets it, a clear request drops it; set wins
module cki_sticky_bit
    import cki_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests
    input wire logic set,
    input wire logic clr,
    // Flag and its next value
    output logic flag_d,
    output logic flag
);
    logic flag_q;

    // Next value: a new event beats a clear in the same cycle
    always_comb begin
        flag_d = flag_q;
        if (clr) begin
            flag_d = 1'b0;
        end
        if (set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule : cki_sticky_bit

// Read-clear latched bit: a read drops only what its setup captured
module cki_rc_bit
    import cki_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Event, read setup and read completion
    input wire logic set,
    input wire logic rd_setup,
    input wire logic rd_done,
    // Latched bit
    output logic flag
);
    logic flag_q;
    logic snap_q;

    // Value returned by the pending read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            snap_q <= 1'b0;
        end else if (rd_setup) begin
            snap_q <= flag_q;
        end
    end

    // A new event beats the clearing read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (rd_done && snap_q) begin
            flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;
endmodule : cki_rc_bit

/* dv/cki_conv_model.sv */
// Converter model: pulses done with a code after a shortened measure.
// Assumes start is a one-cycle pulse on clk from the bench.
`timescale 1ns/1ps
module cki_conv_model #(
    parameter int DELAY = 40
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic [2:0] code,
    // Result
    output logic meas_done_stb,
    output logic [2:0] meas_code
);
    int cnt_q;
    // Measure time, shortened to DELAY cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 0;
        end else if (start) begin
            cnt_q <= DELAY;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    // Code valid only with the strobe, toggles otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meas_done_stb <= 1'b0;
            meas_code <= 3'h0;
        end else begin
            meas_done_stb <= (cnt_q == 1);
            meas_code <= (cnt_q == 1) ? code : ~meas_code;
        end
    end
endmodule : cki_conv_model

/* dv/cki_irq_monitor.sv */
// Checker of the cki_irq ports: bus answer, read fields, done flag.
// Assumes one clock and rst async active high.
`timescale 1ns/1ps
module cki_irq_monitor
    import cki_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire cki_apb_req_t apb_req,
    input wire cki_apb_rsp_t apb_rsp,
    input wire logic id_open_raw,
    input wire logic meas_done_stb,
    input wire logic [2:0] meas_code,
    input wire logic vendor_meas_irq_en,
    input wire logic vendor_code_rd,
    input wire logic id_measure_done,
    input wire logic [2:0] id_resistance_code,
    input wire logic alt_int,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic setup;
    logic ack;
    assign setup = apb_req.psel && !apb_req.penable;
    assign ack = apb_rsp.pready && !apb_rsp.pslverr;
    sequence setup_s;
        setup;
    endsequence
    sequence ack_s;
        ##1 apb_rsp.pready ##1 !apb_rsp.pready;
    endsequence
    ack_one_a: assert property (setup_s |-> ack_s)
        else $error("ready not one cycle");
    en_bits_a: assert property (
        ack && apb_req.paddr inside {8'h74, 8'h78, 8'h7c}
        |-> (apb_rsp.prdata & ~32'h23) == 0) else $error("enable bits");
    state_bits_a: assert property (
        ack && apb_req.paddr == 8'h80 |-> (apb_rsp.prdata & ~32'h79) == 0)
        else $error("state bits");
    mirror_a: assert property (
        setup && !apb_req.pwrite && apb_req.paddr == 8'h80
        && !meas_done_stb && !vendor_code_rd
        |=> apb_rsp.prdata[6:3] == {id_measure_done, id_resistance_code})
        else $error("state mirror");
    done_set_a: assert property (
        meas_done_stb |=> id_measure_done
        && id_resistance_code == $past(meas_code)) else $error("done set");
    done_clr_a: assert property (
        vendor_code_rd && !meas_done_stb |=> !id_measure_done)
        else $error("done not cleared");
    done_hold_a: assert property (
        id_measure_done && !vendor_code_rd |=> id_measure_done)
        else $error("done lost");
    done_alt_a: assert property (
        meas_done_stb && !id_measure_done && vendor_meas_irq_en
        |-> ##[1:3] alt_int) else $error("no alt_int on done");
endmodule : cki_irq_monitor
bind cki_irq cki_irq_monitor u_mon (.*);

/* dv/test_cki_irq.sv */
// Bench for cki_irq: APB master, converter model, expected counts.
// Assumes cki_pkg, the model and the checker compile first.
`timescale 1ns/1ps
module test_cki_irq;
    import cki_pkg::*;
    logic clk = 0;
    logic rst = 1;
    cki_apb_req_t req = '0;
    cki_apb_rsp_t rsp;
    logic open = 0, vend = 0, vrd = 0, start = 0, err;
    logic [2:0] code = 0, mcode, rcode;
    logic stb, done, alt, irq;
    logic [31:0] rd;
    int err_count = 0, checked = 0, seed = 54, alts = 0, ealt = 0, en, n;
    int codes[6] = '{0, 1, 2, 4, 5, 7};
    always #2 clk = ~clk;
    always @(negedge clk) if (alt === 1'b1) alts++;
    cki_irq u_dut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .id_open_raw(open), .meas_done_stb(stb), .meas_code(mcode),
        .vendor_meas_irq_en(vend), .vendor_code_rd(vrd),
        .id_measure_done(done), .id_resistance_code(rcode),
        .alt_int(alt), .irq(irq));
    cki_conv_model #(.DELAY(40)) u_conv (.clk(clk), .rst(rst),
        .start(start), .code(code), .meas_done_stb(stb), .meas_code(mcode));
    task automatic report_and_stop;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bound(input int k);
        if (k >= 99) begin
            err_count++;
            report_and_stop();
        end
    endtask : bound
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) break;
        end
        bound(n);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h74, 32'h0);
        apb(1'b1, 8'h74, 32'hff);
        rchk(8'h7c, 32'h23);
        apb(1'b1, 8'h7c, 32'h21);
        rchk(8'h78, 32'h02);
        apb(1'b1, 8'h78, 32'h01);
        rchk(8'h74, 32'h03);
        apb(1'b1, 8'h80, 32'hff);
        rchk(8'h80, 32'h0);
        apb(1'b0, 8'hfc, 32'h0);
        chk(err, 1);
        // Open edges under each enable pair
        for (en = 0; en < 4; en++) begin
            apb(1'b1, 8'h74, en);
            open <= 1'b1;
            repeat (8) @(posedge clk);
            rchk(8'h80, 32'h1);
            open <= 1'b0;
            repeat (8) @(posedge clk);
            ealt += en[0] + en[1];
            rchk(8'h84, (en != 0) ? 1 : 0);
            rchk(8'h84, 32'h0);
            chk(alts, ealt);
        end
        // Interrupt masked, enabled, cleared
        rchk(8'h88, 32'h1);
        chk(irq, 0);
        apb(1'b1, 8'h90, 32'h3);
        repeat (2) @(negedge clk);
        chk(irq, 1);
        apb(1'b1, 8'h8c, 32'h3);
        repeat (2) @(negedge clk);
        chk(irq, 0);
        // Measurements under each enable source
        for (en = 0; en < 4; en++) begin
            apb(1'b1, 8'h74, {en[0], 5'h0});
            vend <= en[1];
            code <= 3'(codes[$unsigned($random(seed)) % 6]);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            for (n = 0; n < 99 && done !== 1'b1; n++) @(negedge clk);
            bound(n);
            ealt += (en != 0);
            repeat (4) @(posedge clk);
            rchk(8'h80, {code, 3'h0} | 32'h40);
            rchk(8'h80, {code, 3'h0} | 32'h40);
            rchk(8'h84, (en != 0) ? 8 : 0);
            vrd <= 1'b1;
            @(posedge clk);
            vrd <= 1'b0;
            @(negedge clk);
            chk(done, 0);
            chk(alts, ealt);
        end
        // Reset again with the pin floating
        @(posedge clk);
        open <= 1'b1;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h74, 32'h0);
        repeat (4) @(posedge clk);
        rchk(8'h80, 32'h1);
        rchk(8'h84, 32'h0);
        chk(alts, ealt);
        report_and_stop();
    end
endmodule : test_cki_irq
